// >>> include/acps_regs.vh
// register offsets, field positions and reset values of the chip control/status block
// included by the design files; definitions only
`ifndef ACPS_REGS_VH
`define ACPS_REGS_VH

`define ACPS_CTRL_OFS        8'h30
`define ACPS_ROMCFG_OFS      8'h34
`define ACPS_ROMWIN_OFS      8'h38
`define ACPS_ROMDATA_OFS     8'h3C

`define ACPS_BIT_ROM_OFF     0
`define ACPS_BIT_ROM_SIZE    1
`define ACPS_BIT_CAP_10M     4
`define ACPS_BIT_CAP_100M    5
`define ACPS_BIT_CAP_1000M   6
`define ACPS_BIT_FIBER       7

`define ACPS_CTRL_RST        8'h00
`define ACPS_ROM_BASE_RST    32'h000C_0000
`define ACPS_ROM_32K_MASK    32'h0000_7FFF
`define ACPS_ROM_64K_MASK    32'h0000_FFFF
`define ACPS_ZERO32          32'h0000_0000

`define ACPS_HTRANS_NONSEQ   2'h2
`define ACPS_HTRANS_SEQ      2'h3
`define ACPS_HSIZE_WORD      3'h2

`endif

// >>> src/acps_sync.v
// two-flop synchroniser bank for the phy strap/capability pins
// assumes inputs are quasi-static levels from outside the core_clk domain
`timescale 1ns/1ps
`default_nettype none
module acps_sync #(
  parameter W = 4
) (
  input  wire         core_clk,
  input  wire         arst_n,
  input  wire [W-1:0] d_async,
  output wire [W-1:0] q_sync
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_r;
      reg sync_r;
      // first stage feeds only the second stage
      always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= d_async[i];
          sync_r <= meta_r;
        end
      end
      assign q_sync[i] = sync_r;
    end
  endgenerate
endmodule
`default_nettype wire

// >>> src/acps_top.v
// chip control/status register block with ahb-lite slave and expansion rom gate
// assumes one ahb-lite master, word transfers only, phy pins static outside reset
// Summary of operation
// [R1] rom off: rom reads zero, writes dropped
// [R2] software writes zero to reserved bits
// [R3] bit 1 selects 32 or 64 KB rom
// [R4] bit 4 reports phy 10 Mbps support
// [R5] bit 5 reports phy 100 Mbps support
// [R6] bit 6 reports phy 1000 Mbps support
// [R7] bit 7 reports fiber versus twisted pair
// [R8] software decodes media with speed flags
// [R9] writes to capability flags are ignored
`timescale 1ns/1ps
`default_nettype none
`include "acps_regs.vh"
module acps_top #(
  parameter ROM_AW = 16
) (
  input  wire              core_clk,
  input  wire              arst_n,
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output reg  [31:0]       hrdata,
  output reg               hreadyout,
  output reg               hresp,
  input  wire              phy_cap_10m,
  input  wire              phy_cap_100m,
  input  wire              phy_cap_1000m,
  input  wire              phy_fiber_flag,
  input  wire              rom_space_hit,
  input  wire [31:0]       rom_space_addr,
  input  wire              rom_space_wr,
  input  wire [31:0]       rom_space_wdata,
  output reg  [31:0]       rom_space_rdata,
  input  wire [31:0]       rom_rd_data,
  output reg               rom_rd_en,
  output reg               rom_wr_en,
  output reg  [ROM_AW-1:0] rom_addr,
  output reg  [31:0]       rom_wdata,
  output reg               rom_size_64k
);

  // phy capability pins are straps from outside, so resynchronise them
  wire [3:0] cap_sync;

  acps_sync #(
    .W (4)
  ) u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .d_async  ({phy_fiber_flag, phy_cap_1000m, phy_cap_100m, phy_cap_10m}),
    .q_sync   (cap_sync)
  );

  reg        rom_window_off_r;
  reg        rom_size_sel_r;
  reg [31:0] rom_base_r;
  reg        wr_pend_r;
  reg [7:0]  wr_ofs_r;
  reg [31:0] rom_acc_r;

  wire       xfer_go;
  wire [7:0] acc_ofs;
  wire [7:0] ctrl_rd_val;
  wire [31:0] rom_mask;
  wire [31:0] rom_ofs_full;

  assign xfer_go = hsel & hready & htrans[1];
  assign acc_ofs = haddr[7:0];

  // capability flags come from the pins only; no write path reaches them
  assign ctrl_rd_val = {cap_sync[3],                  // [R7]
                        cap_sync[2],                  // [R6]
                        cap_sync[1],                  // [R5]
                        cap_sync[0],                  // [R4] [R9]
                        2'b00,
                        rom_size_sel_r,               // [R3]
                        1'b0};

  assign rom_mask     = rom_size_sel_r ? `ACPS_ROM_64K_MASK : `ACPS_ROM_32K_MASK; // [R3]
  assign rom_ofs_full = (rom_space_addr - rom_base_r) & rom_mask;
  // address phase captured; data phase completes next cycle with zero wait states
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= `ACPS_CTRL_RST;
    end else begin
      // reads are answered from the address phase, so only writes need the offset held
      wr_pend_r <= xfer_go & hwrite;
      if (xfer_go) begin
        wr_ofs_r <= acc_ofs;
      end
    end
  end

  // register writes; reserved bits 2,3 are not stored and bits 4..7 are read-only
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rom_window_off_r <= 1'b0;                       // [R1]
      rom_size_sel_r   <= 1'b0;
      rom_base_r       <= `ACPS_ROM_BASE_RST;
      rom_acc_r        <= `ACPS_ZERO32;
    end else if (wr_pend_r) begin
      case (wr_ofs_r)
        `ACPS_CTRL_OFS: begin
          rom_size_sel_r <= hwdata[`ACPS_BIT_ROM_SIZE]; // [R3] [R9]
        end
        `ACPS_ROMCFG_OFS: begin
          // disable bit kept apart from the control word so that
          // software obeying the write-zero convention cannot trip it
          rom_window_off_r <= hwdata[`ACPS_BIT_ROM_OFF]; // [R1] [R2]
        end
        `ACPS_ROMWIN_OFS: begin
          rom_base_r <= hwdata;
        end
        `ACPS_ROMDATA_OFS: begin
          rom_acc_r <= hwdata;
        end
        default: begin
          rom_acc_r <= rom_acc_r;
        end
      endcase
    end
  end

  // read data is registered so hrdata comes straight from a flop
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata    <= `ACPS_ZERO32;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (xfer_go & ~hwrite) begin
        case (acc_ofs)
          `ACPS_CTRL_OFS:    hrdata <= {24'h00_0000, ctrl_rd_val};
          `ACPS_ROMCFG_OFS:  hrdata <= {31'h0000_0000, rom_window_off_r};
          `ACPS_ROMWIN_OFS:  hrdata <= rom_base_r;
          `ACPS_ROMDATA_OFS: hrdata <= rom_acc_r;
          default:           hrdata <= `ACPS_ZERO32;
        endcase
      end
    end
  end

  // expansion rom space gate: a disabled window reads zero and swallows writes
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rom_rd_en       <= 1'b0;
      rom_wr_en       <= 1'b0;
      rom_addr        <= {ROM_AW{1'b0}};
      rom_wdata       <= `ACPS_ZERO32;
      rom_space_rdata <= `ACPS_ZERO32;
      rom_size_64k    <= 1'b0;
    end else begin
      rom_size_64k <= rom_size_sel_r;                 // [R3]
      rom_rd_en    <= rom_space_hit & ~rom_space_wr & ~rom_window_off_r;  // [R1]
      rom_wr_en    <= rom_space_hit & rom_space_wr & ~rom_window_off_r;   // [R1]
      rom_addr     <= rom_ofs_full[ROM_AW-1:0];
      rom_wdata    <= rom_space_wdata;
      if (rom_window_off_r)
        rom_space_rdata <= `ACPS_ZERO32;              // [R1]
      else
        rom_space_rdata <= rom_rd_data;
    end
  end

endmodule
`default_nettype wire

// >>> bench/acps_phy_model.sv
// far-side model: phy capability pins and expansion rom
// assumes rom_addr and rom_rd_en come straight from acps_top
`timescale 1ns/1ps
`default_nettype none
module acps_phy_model (
  input  wire logic [3:0]  caps,
  input  wire logic [15:0] rom_addr,
  input  wire logic        rom_rd_en,
  output logic             phy_cap_10m,
  output logic             phy_cap_100m,
  output logic             phy_cap_1000m,
  output logic             phy_fiber_flag,
  output logic      [31:0] rom_rd_data
);
  assign {phy_fiber_flag, phy_cap_1000m, phy_cap_100m, phy_cap_10m} = caps;
  // idle rom bus shows the inverse so a leaky gate cannot hide
  assign rom_rd_data = rom_rd_en ? {16'h5A5A, rom_addr} : ~{16'h5A5A, rom_addr};
endmodule
`default_nettype wire

// >>> bench/acps_top_sva.sv
// checker on the ports of acps_top
// assumes phy pins stay still around reads of the control word
`timescale 1ns/1ps
`default_nettype none
module acps_top_sva #(parameter ROM_AW = 16) (
  input wire logic core_clk, arst_n, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [31:0] haddr, hrdata, rom_space_rdata, rom_rd_data,
  input wire logic [1:0] htrans,
  input wire logic phy_cap_10m, phy_cap_100m, phy_cap_1000m, phy_fiber_flag,
  input wire logic rom_space_hit, rom_rd_en, rom_wr_en, rom_size_64k,
  input wire logic [ROM_AW-1:0] rom_addr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire rd30 = hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h30;
  wire [3:0] caps = {phy_fiber_flag, phy_cap_1000m, phy_cap_100m, phy_cap_10m};
  a_caps_read: assert property (rd30 |=> hrdata[7:4] == $past(caps, 3))
    else $error("capability flags wrong");
  a_rsvd_zero: assert property (rd30 |=> hrdata[31:8] == 24'h0 && hrdata[3:2] == 2'h0 && !hrdata[0])
    else $error("reserved bits not zero");
  a_size_read: assert property (rd30 |=> hrdata[1] == rom_size_64k)
    else $error("size bit mismatch");
  a_size_mask: assert property (rom_rd_en && !rom_size_64k |-> !rom_addr[15])
    else $error("32k mask broken");
  a_gate_cause: assert property (rom_rd_en || rom_wr_en |-> $past(rom_space_hit))
    else $error("rom strobe without hit");
  a_rom_data: assert property (rom_rd_en |=> rom_space_rdata == $past(rom_rd_data))
    else $error("rom data not passed");
  a_off_zero: assert property (rom_space_rdata != $past(rom_rd_data) |-> rom_space_rdata == 32'h0)
    else $error("rom data leaked");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not okay");
endmodule
`default_nettype wire

// >>> bench/acps_top_test.sv
// self-checking bench for acps_top
// assumes the phy model on the pins and an ahb-lite master here
`timescale 1ns/1ps
`default_nettype none
module acps_top_test;
  logic core_clk = 0, arst_n = 0, hsel = 0, hwrite = 0, rd_ph = 0, rom_space_hit = 0, rom_space_wr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, rom_space_addr = 0, st = 32'h0000_3001, d, exp_q[$];
  logic [3:0] caps = 0;
  int errors = 0, compares = 0;
  wire [31:0] hrdata, rom_space_rdata, rom_rd_data, rom_wdata, rom_space_wdata = hwdata;
  wire hreadyout, hresp, rom_rd_en, rom_wr_en, rom_size_64k, phy_cap_10m, phy_cap_100m, phy_cap_1000m, phy_fiber_flag;
  wire [15:0] rom_addr;
  acps_top dut (.*, .hsize(3'h2), .hready(hreadyout));
  acps_phy_model phy (.*);
  initial forever #25 core_clk = ~core_clk;
  function automatic logic [31:0] rnd();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic ahb(logic w, logic [7:0] a, logic [31:0] wd, logic [31:0] e);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= wd; rd_ph <= !w;
    if (!w) exp_q.push_back(e);
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd_ph <= 0;
  endtask
  // a read result is only trusted once its data phase closes
  always @(posedge core_clk) if (rd_ph && hreadyout === 1'b1) chk("hrdata", hrdata, exp_q.pop_front());
  task automatic rom(logic w, logic [31:0] a, logic [15:0] ea, logic on);
    rom_space_hit <= 1; rom_space_wr <= w; rom_space_addr <= a;
    @(posedge core_clk);
    rom_space_hit <= 0;
    #1 chk("rom_en", {30'h0, rom_rd_en, rom_wr_en}, {30'h0, !w && on, w && on});
    if (on) chk("rom_addr", {16'h0, rom_addr}, {16'h0, ea});
    if (w && on) chk("rom_wdata", rom_wdata, hwdata);
    @(posedge core_clk);
    #1 chk("rom_rdata", rom_space_rdata, !on ? 32'h0 : w ? ~{16'h5A5A, ea} : {16'h5A5A, ea});
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    arst_n <= 1;
    for (int i = 0; i < 16; i++) begin
      caps <= i[3:0];
      repeat (4) @(posedge core_clk);
      d = rnd() & 32'hFFFF_FFF2;
      ahb(1, 8'h30, d, 0);
      ahb(0, 8'h30, 0, {24'h0, i[3:0], 2'h0, d[1], 1'h0});
    end
    $display("test caps done");
    for (int s = 0; s < 2; s++) begin
      ahb(1, 8'h30, s << 1, 0);
      @(posedge core_clk);
      rom(0, 32'h000D_8004, s ? 16'h8004 : 16'h0004, 1);
      rom(1, 32'h000C_1230, 16'h1230, 1);
    end
    $display("test rom size done");
    ahb(1, 8'h34, 1, 0);
    ahb(0, 8'h34, 0, 1);
    ahb(0, 8'h40, 0, 0);
    rom(0, 32'h000C_0010, 0, 0);
    rom(1, 32'h000C_0010, 0, 0);
    arst_n <= 0;
    @(posedge core_clk);
    arst_n <= 1;
    @(posedge core_clk);
    ahb(0, 8'h34, 0, 0);
    @(posedge core_clk);
    $display("test rom off done");
    test_done();
  end
  initial begin
    #100000;
    errors++;
    test_done();
  end
endmodule
bind acps_top acps_top_sva #(.ROM_AW(ROM_AW)) chk (.*);
`default_nettype wire
